// ### hdl/lm_intr_unit.sv
`timescale 1ns/10ps
module lm_intr_unit (
	input wire logic MCLK, // core clock, 40 MHz
	input wire logic RESET_N, // asynchronous reset
	input wire logic HSEL, // slave select
	input wire logic [31:0] HADDR, // byte address
	input wire logic [1:0] HTRANS, // transfer type
	input wire logic HWRITE, // write not read
	input wire logic [2:0] HSIZE, // word transfers only
	input wire logic [31:0] HWDATA, // write data
	input wire logic HREADY, // bus ready
	input wire logic EXT_INT, // external interrupt request level
	input wire logic [7:0] EXT_VEC, // external interrupt vector
	output logic [31:0] HRDATA, // read data
	output logic HREADYOUT, // slave ready
	output logic HRESP, // always OKAY
	output logic HANDLER_64, // core runs 64-bit code
	output logic PROT_FAULT, // protection fault pulse
	output logic EXT_ACK // external request taken pulse
);
	import lmint_pkg::*;
	typedef struct packed {
		state_e st;
		logic long_en;
		logic code64;
		logic [1:0] cur_priv;
		logic [3:0] prio;
		logic [9:0] gate;
		logic [7:0] vec;
		logic ret;
		logic op64;
		logic tgt64;
		logic ss_null_in;
		logic [1:0] ret_priv;
		logic fault;
		logic switched;
		logic ss_null_loaded;
		logic [3:0] items;
		logic [3:0] slot;
		logic [11:0] idx;
		logic [63:0] sp;
		logic [63:0] saved_sp;
		logic [15:0] ss_sel;
		logic [63:0] tbase;
		logic [15:0] tlimit;
		logic task_reg_ok;
		logic [15:0] iomap;
		logic [9:0][63:0] tsb;
		logic [7:0] a_addr;
		logic a_wr;
		logic a_rd;
		logic [31:0] rdata;
		logic go;
		logic fault_pulse;
		logic ack_pulse;
		logic [3:0] cls;
	} unit_s;
	unit_s q, d;
	logic [8:0] ext_sync;
	logic mv_busy;
	logic mv_done;
	logic [7:0] mv_bytes;
	logic accept;
	logic ent_bad;
	logic ret_bad;
	logic up_priv;
	logic down_priv;
	logic [2:0] alt_idx;

	function automatic logic [11:0] table_index(input logic [7:0] v, input logic lm);
		table_index = lm ? {v, 4'h0} : {1'b0, v, 3'h0};
	endfunction : table_index

	function automatic logic [63:0] word_merge(input logic [63:0] old, input logic hi,
		input logic [31:0] w);
		word_merge = hi ? {w, old[31:0]} : {old[63:32], w};
	endfunction : word_merge

	sync_pair u_sync (
		.clk(MCLK),
		.rst_n(RESET_N),
		.async_in({EXT_INT, EXT_VEC}),
		.sync_out(ext_sync)
	);

	frame_mover u_mover (
		.clk(MCLK),
		.rst_n(RESET_N),
		.load(q.go),
		.items(q.items),
		.item_bytes(q.slot),
		.busy(mv_busy),
		.done(mv_done),
		.total_bytes(mv_bytes)
	);

	assign accept = HSEL && HTRANS[1] && HREADY;
	assign alt_idx = q.gate[6:4];
	assign up_priv = (q.gate[9:8] < q.cur_priv);
	assign down_priv = (q.ret_priv > q.cur_priv);
	// long mode has no task switching and no 16-bit call gates
	assign ent_bad = q.long_en && (q.gate[3:0] == GT_TASK || q.gate[3:0] == GT_CALL16);
	assign ret_bad = q.long_en && q.ss_null_in && !(q.tgt64 && q.ret_priv != PRIV_USER);

	always_comb begin
		d = q;
		d.go = 1'b0;
		d.fault_pulse = 1'b0;
		d.ack_pulse = 1'b0;
		d.a_wr = 1'b0;
		d.a_rd = 1'b0;
		// bus address phase; reads get one wait state so writes land first
		if (accept) begin
			d.a_addr = HADDR[7:0];
			d.a_wr = HWRITE;
			d.a_rd = !HWRITE;
		end
		if (q.a_rd) begin
			d.rdata = 32'h0000_0000;
			unique case (q.a_addr)
				A_CTRL: d.rdata = {28'h000_0000, q.cur_priv, q.code64, q.long_en};
				A_PRIO: d.rdata = {28'h000_0000, q.prio};
				A_GATE: d.rdata = {22'h00_0000, q.gate};
				A_STATUS: d.rdata = {16'h0000, q.cls, q.slot, q.items, q.ss_null_loaded,
					q.switched, q.fault, q.st != S_IDLE};
				A_INDEX: d.rdata = {20'h0_0000, q.idx};
				A_SP_LO: d.rdata = q.sp[31:0];
				A_SP_HI: d.rdata = q.sp[63:32];
				A_SAVED_LO: d.rdata = q.saved_sp[31:0];
				A_SAVED_HI: d.rdata = q.saved_sp[63:32];
				A_TBASE_LO: d.rdata = q.tbase[31:0];
				A_TBASE_HI: d.rdata = q.tbase[63:32];
				A_TLIMIT: d.rdata = {16'h0000, q.tlimit};
				A_TASKREG: d.rdata = {31'h0000_0000, q.task_reg_ok};
				A_IOMAP: d.rdata = {16'h0000, q.iomap};
				A_SSSEL: d.rdata = {16'h0000, q.ss_sel};
				default: begin
					if (q.a_addr >= A_TSB_FIRST && q.a_addr <= A_TSB_LAST) begin
						d.rdata = q.a_addr[2] ? q.tsb[4'(q.a_addr[7:3] - 5'h08)][63:32]
							: q.tsb[4'(q.a_addr[7:3] - 5'h08)][31:0];
					end
				end
			endcase
		end
		// bus data phase of a write
		if (q.a_wr) begin
			unique case (q.a_addr)
				A_CTRL: begin
					d.long_en = HWDATA[0];
					d.code64 = HWDATA[1];
					d.cur_priv = HWDATA[3:2];
				end
				A_PRIO: d.prio = HWDATA[3:0];
				A_GATE: d.gate = HWDATA[9:0];
				A_CMD: begin
					// commands while busy are dropped
					if (q.st == S_IDLE) begin
						d.vec = HWDATA[7:0];
						d.ret = HWDATA[8];
						d.op64 = HWDATA[9];
						d.tgt64 = HWDATA[10];
						d.ss_null_in = HWDATA[11];
						d.ret_priv = HWDATA[13:12];
						d.st = S_CHECK;
					end
				end
				A_STATUS: begin
					if (HWDATA[1]) begin
						d.fault = 1'b0;
					end
				end
				A_SP_LO: d.sp = word_merge(q.sp, 1'b0, HWDATA);
				A_SP_HI: d.sp = word_merge(q.sp, 1'b1, HWDATA);
				A_TBASE_LO: d.tbase = word_merge(q.tbase, 1'b0, HWDATA);
				// a write from legacy code clears the upper 32 bits of the base
				A_TBASE_HI: d.tbase = word_merge(q.tbase, 1'b1,
					q.code64 ? HWDATA : 32'h0000_0000);
				A_TLIMIT: d.tlimit = HWDATA[15:0];
				A_TASKREG: begin
					// in long mode only the 64-bit type, and only from 64-bit code
					d.task_reg_ok = !q.long_en || (HWDATA[3:0] == TSB_TYPE64 && q.code64);
					if (q.long_en && !(HWDATA[3:0] == TSB_TYPE64 && q.code64)) begin
						d.fault = 1'b1;
						d.fault_pulse = 1'b1;
					end
				end
				A_IOMAP: d.iomap = HWDATA[15:0];
				default: begin
					if (q.a_addr >= A_TSB_FIRST && q.a_addr <= A_TSB_LAST) begin
						d.tsb[4'(q.a_addr[7:3] - 5'h08)] = word_merge(
							q.tsb[4'(q.a_addr[7:3] - 5'h08)], q.a_addr[2], HWDATA);
					end
				end
			endcase
		end
		unique case (q.st)
			S_IDLE: begin
				// external request only above the current task priority
				if (ext_sync[8] && ext_sync[7:4] != 4'h0 && ext_sync[7:4] > q.prio
					&& !(q.a_wr && q.a_addr == A_CMD)) begin
					d.vec = ext_sync[7:0];
					d.cls = ext_sync[7:4];
					d.ret = 1'b0;
					d.ack_pulse = 1'b1;
					d.st = S_CHECK;
				end
			end
			S_CHECK: begin
				d.switched = 1'b0;
				d.ss_null_loaded = 1'b0;
				d.idx = table_index(q.vec, q.long_en);
				if (!q.ret && ent_bad) begin
					d.fault = 1'b1;
					d.fault_pulse = 1'b1;
					d.st = S_IDLE;
				end else if (!q.ret) begin
					d.slot = q.long_en ? SLOT64 : (q.gate[7] ? SLOT32 : SLOT16);
					d.items = (q.long_en || up_priv) ? ITEMS_FULL : ITEMS_SHORT;
					d.saved_sp = q.sp;
					if (q.long_en && alt_idx != 3'h0) begin
						d.sp = q.tsb[ALT_BASE + {1'b0, alt_idx}];
						d.switched = 1'b1;
					end else if (up_priv) begin
						d.sp = q.tsb[{2'h0, q.gate[9:8]}];
						d.switched = 1'b1;
					end
					if (q.long_en && (up_priv || alt_idx != 3'h0)) begin
						d.ss_sel = SEL_NULL;
						d.ss_null_loaded = 1'b1;
					end
					d.cur_priv = q.gate[9:8];
					d.code64 = q.long_en ? 1'b1 : q.code64;
					d.go = 1'b1;
					d.st = S_MOVE;
				end else if (ret_bad) begin
					d.fault = 1'b1;
					d.fault_pulse = 1'b1;
					d.st = S_IDLE;
				end else begin
					d.slot = (q.long_en && q.code64 && q.op64) ? SLOT64 : SLOT32;
					d.items = ((q.long_en && q.code64) || down_priv) ? ITEMS_FULL
						: ITEMS_SHORT;
					if (q.long_en && q.ss_null_in) begin
						d.ss_sel = SEL_NULL;
						d.ss_null_loaded = 1'b1;
					end
					d.cur_priv = q.ret_priv;
					d.code64 = q.long_en && q.tgt64;
					d.go = 1'b1;
					d.st = S_MOVE;
				end
			end
			S_MOVE: begin
				if (mv_done) begin
					d.sp = q.ret ? q.sp + {56'h0000_0000_0000_00, mv_bytes}
						: q.sp - {56'h0000_0000_0000_00, mv_bytes};
					d.st = S_DONE;
				end
			end
			S_DONE: d.st = S_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= '0;
			q.st <= S_IDLE;
			q.prio <= RST_PRIO;
			q.gate <= RST_GATE;
			q.cur_priv <= RST_PRIV;
		end else begin
			q <= d;
		end
	end

	assign HRDATA = q.rdata;
	assign HREADYOUT = !q.a_rd;
	assign HRESP = 1'b0;
	assign HANDLER_64 = q.code64;
	assign PROT_FAULT = q.fault_pulse;
	assign EXT_ACK = q.ack_pulse;

	// entry, return, external request and frame move checks
	property p_index_long;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && q.long_en) |=> (q.idx == {$past(q.vec), 4'h0});
	endproperty
	a_index_long: assert property (p_index_long) else $error("long index not vector*16");
	property p_index_legacy;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && !q.long_en) |=> (q.idx == {1'b0, $past(q.vec), 3'h0});
	endproperty
	a_index_legacy: assert property (p_index_legacy) else $error("legacy index not vector*8");
	property p_task_gate;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && !q.ret && q.long_en && q.gate[3:0] == GT_TASK)
			|=> PROT_FAULT && q.st == S_IDLE;
	endproperty
	a_task_gate: assert property (p_task_gate) else $error("task gate not refused");
	property p_long_frame;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && !q.ret && q.long_en && !ent_bad)
			|=> q.slot == SLOT64 && q.items == ITEMS_FULL && HANDLER_64;
	endproperty
	a_long_frame: assert property (p_long_frame) else $error("long frame shape wrong");
	property p_legacy_frame;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && !q.ret && !q.long_en && !up_priv && !q.gate[7])
			|=> q.slot == SLOT16 && q.items == ITEMS_SHORT;
	endproperty
	a_legacy_frame: assert property (p_legacy_frame) else $error("legacy frame shape wrong");
	property p_null_sel;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && !q.ret && q.long_en && !ent_bad && up_priv)
			|=> q.ss_sel == SEL_NULL && q.switched && q.saved_sp == $past(q.sp);
	endproperty
	a_null_sel: assert property (p_null_sel) else $error("stack switch state wrong");
	property p_ret64;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && q.ret && q.long_en && q.code64 && q.op64 && !ret_bad)
			|=> q.items == ITEMS_FULL && q.slot == SLOT64;
	endproperty
	a_ret64: assert property (p_ret64) else $error("64-bit return pops wrong");
	property p_null_refused;
		@(posedge MCLK) disable iff (!RESET_N)
		(q.st == S_CHECK && q.ret && q.long_en && q.ss_null_in && q.ret_priv == PRIV_USER)
			|=> PROT_FAULT;
	endproperty
	a_null_refused: assert property (p_null_refused) else $error("null selector accepted");
	property p_ext_class;
		@(posedge MCLK) disable iff (!RESET_N)
		EXT_ACK |-> q.cls > q.prio && q.cls != 4'h0 && q.st == S_CHECK;
	endproperty
	a_ext_class: assert property (p_ext_class) else $error("request taken at low class");
	property p_move_ends;
		@(posedge MCLK) disable iff (!RESET_N)
		$rose(q.st == S_MOVE) |-> ##[1:18] q.st == S_DONE;
	endproperty
	a_move_ends: assert property (p_move_ends) else $error("frame move never ends");
	c_long_entry: cover property (@(posedge MCLK) q.st == S_CHECK && q.long_en && !q.ret);
	c_return: cover property (@(posedge MCLK) q.st == S_CHECK && q.ret && !ret_bad);
	c_fault: cover property (@(posedge MCLK) PROT_FAULT);
	c_ext: cover property (@(posedge MCLK) EXT_ACK);
endmodule : lm_intr_unit

// ### hdl/lmint_pkg.sv
package lmint_pkg;
	// register byte offsets, word aligned on the bus
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PRIO = 8'h04;
	localparam logic [7:0] A_GATE = 8'h08;
	localparam logic [7:0] A_CMD = 8'h0C;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_INDEX = 8'h14;
	localparam logic [7:0] A_SP_LO = 8'h18;
	localparam logic [7:0] A_SP_HI = 8'h1C;
	localparam logic [7:0] A_SAVED_LO = 8'h20;
	localparam logic [7:0] A_SAVED_HI = 8'h24;
	localparam logic [7:0] A_TBASE_LO = 8'h28;
	localparam logic [7:0] A_TBASE_HI = 8'h2C;
	localparam logic [7:0] A_TLIMIT = 8'h30;
	localparam logic [7:0] A_TASKREG = 8'h34;
	localparam logic [7:0] A_IOMAP = 8'h38;
	localparam logic [7:0] A_SSSEL = 8'h3C;
	localparam logic [7:0] A_TSB_FIRST = 8'h40;
	localparam logic [7:0] A_TSB_LAST = 8'h8C;
	// gate descriptor type codes
	localparam logic [3:0] GT_CALL16 = 4'h4;
	localparam logic [3:0] GT_TASK = 4'h5;
	localparam logic [3:0] GT_CALL32 = 4'hC;
	// task state block entry: privilege stacks 0..2, then alternate stacks 1..7
	localparam logic [3:0] ALT_BASE = 4'h2;
	localparam logic [3:0] TSB_TYPE64 = 4'h9;
	// frame geometry
	localparam logic [3:0] SLOT64 = 4'h8;
	localparam logic [3:0] SLOT32 = 4'h4;
	localparam logic [3:0] SLOT16 = 4'h2;
	localparam logic [3:0] ITEMS_FULL = 4'h5;
	localparam logic [3:0] ITEMS_SHORT = 4'h3;
	localparam logic [1:0] PRIV_USER = 2'h3;
	localparam logic [15:0] SEL_NULL = 16'h0000;
	// reset values
	localparam logic [3:0] RST_PRIO = 4'h0;
	localparam logic [9:0] RST_GATE = 10'h00E;
	localparam logic [1:0] RST_PRIV = 2'h0;
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_CHECK = 4'b0010,
		S_MOVE = 4'b0100,
		S_DONE = 4'b1000
	} state_e;
endpackage : lmint_pkg

// ### hdl/sync_pair.sv
`timescale 1ns/10ps
module sync_pair (
	input wire logic clk, // core clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic [8:0] async_in, // levels from outside the clock domain
	output logic [8:0] sync_out // levels safe to read
);
	typedef struct packed {
		logic [8:0] first;
		logic [8:0] second;
	} sync_s;
	sync_s q, d;
	// first stage feeds the second stage only
	always_comb begin
		d = q;
		d.first = async_in;
		d.second = q.first;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign sync_out = q.second;
endmodule : sync_pair

// ### hdl/frame_mover.sv
`timescale 1ns/10ps
module frame_mover (
	input wire logic clk, // core clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic load, // start moving a frame
	input wire logic [3:0] items, // number of frame slots
	input wire logic [3:0] item_bytes, // width of one slot in bytes
	output logic busy, // slots still to move
	output logic done, // pulse after the last slot
	output logic [7:0] total_bytes // bytes moved so far
);
	typedef struct packed {
		logic [3:0] left;
		logic [3:0] step;
		logic [7:0] total;
		logic done;
	} mover_s;
	mover_s q, d;
	// one slot per cycle; total is the stack pointer adjustment
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (load) begin
			d.left = items;
			d.step = item_bytes;
			d.total = 8'h00;
		end else if (q.left != 4'h0) begin
			d.left = q.left - 4'h1;
			d.total = q.total + {4'h0, q.step};
			d.done = (q.left == 4'h1);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign busy = (q.left != 4'h0);
	assign done = q.done;
	assign total_bytes = q.total;
endmodule : frame_mover

// ### sim/ext_source.sv
`timescale 1ns/10ps
module ext_source (
	input wire logic clk, // core clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic req, // bench asks for a request
	input wire logic [7:0] vec, // vector to present
	input wire logic ack, // taken pulse from the unit
	output logic ext_int, // request level
	output logic [7:0] ext_vec, // vector while requesting
	output logic taken // last request was acknowledged
);
	logic req_q;
	// falling edge keeps the model clear of the unit's own edge
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_int <= 1'b0;
			ext_vec <= 8'h00;
			taken <= 1'b0;
			req_q <= 1'b0;
		end else begin
			req_q <= req;
			if (ack) begin
				ext_int <= 1'b0;
				ext_vec <= ~ext_vec;
				taken <= 1'b1;
			end else if (req && !req_q) begin
				ext_int <= 1'b1;
				ext_vec <= vec;
				taken <= 1'b0;
			end else if (!req) begin
				ext_int <= 1'b0;
			end
		end
	end
endmodule : ext_source

// ### sim/lm_intr_unit_tb.sv
`timescale 1ns/10ps
module lm_intr_unit_tb;
	import lmint_pkg::*;
	typedef struct {
		logic [3:0] ctrl;
		logic [11:0] gate;
		logic [15:0] cmd;
		logic fault;
		logic [3:0] items;
		logic [3:0] slot;
		logic [15:0] sp;
		logic [11:0] idx;
	} op_s;
	op_s ops [10] = '{
		'{4'hD, 12'h00E, 16'h0021, 1'b0, 4'h5, 4'h8, 16'h0FD8, 12'h210},
		'{4'h1, 12'h00E, 16'h00FF, 1'b0, 4'h5, 4'h8, 16'h4FD8, 12'hFF0},
		'{4'h3, 12'h01E, 16'h0010, 1'b0, 4'h5, 4'h8, 16'h2FD8, 12'h100},
		'{4'h0, 12'h08E, 16'h0021, 1'b0, 4'h3, 4'h4, 16'h4FF4, 12'h108},
		'{4'h0, 12'h00E, 16'h0021, 1'b0, 4'h3, 4'h2, 16'h4FFA, 12'h108},
		'{4'h3, 12'h005, 16'h0021, 1'b1, 4'h0, 4'h0, 16'h0000, 12'h000},
		'{4'h3, 12'h004, 16'h0021, 1'b1, 4'h0, 4'h0, 16'h0000, 12'h000},
		'{4'h3, 12'h00E, 16'h0F00, 1'b0, 4'h5, 4'h8, 16'h5028, 12'h000},
		'{4'h3, 12'h00E, 16'h3F00, 1'b1, 4'h0, 4'h0, 16'h0000, 12'h000},
		'{4'h1, 12'h00E, 16'h0100, 1'b0, 4'h3, 4'h4, 16'h500C, 12'h000}
	};
	logic MCLK = 1'b0;
	logic RESET_N = 1'b0;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic [1:0] HTRANS = 2'b00;
	logic [31:0] HADDR = 32'h0000_0000;
	logic [31:0] HWDATA = 32'h0000_0000;
	logic [31:0] HRDATA;
	logic HREADYOUT, HRESP, HANDLER_64, PROT_FAULT, EXT_ACK, EXT_INT;
	logic [7:0] EXT_VEC;
	logic [7:0] vec = 8'h00;
	logic req = 1'b0;
	logic taken, rdy_s, h64_s, resp_s;
	logic [31:0] rd_s, rd;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_fault = 0;
	int f0, i, k;

	always #12.5 MCLK = ~MCLK;
	// sampled mid-cycle so every edge sees settled slave outputs
	always @(negedge MCLK) begin
		rdy_s = HREADYOUT;
		rd_s = HRDATA;
		h64_s = HANDLER_64;
		resp_s = HRESP;
		if (PROT_FAULT === 1'b1) n_fault++;
	end

	lm_intr_unit dut (.MCLK(MCLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .EXT_INT(EXT_INT), .EXT_VEC(EXT_VEC), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .HANDLER_64(HANDLER_64),
		.PROT_FAULT(PROT_FAULT), .EXT_ACK(EXT_ACK));
	ext_source src (.clk(MCLK), .rst_n(RESET_N), .req(req), .vec(vec), .ack(EXT_ACK),
		.ext_int(EXT_INT), .ext_vec(EXT_VEC), .taken(taken));

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: flag %b want %b", $time, got, exp);
		end
	endtask : chk_bit

	// one single word transfer; an idle edge separates transfers
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HWRITE <= wr;
		HADDR <= {24'h00_0000, a};
		do @(posedge MCLK); while (rdy_s !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= d;
		do @(posedge MCLK); while (rdy_s !== 1'b1);
		rd = rd_s;
	endtask : bus

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk_word(rd, exp);
	endtask : rd_chk

	task automatic wait_idle();
		k = 0;
		do begin
			bus(1'b0, A_STATUS, 32'h0000_0000);
			k++;
		end while (rd[0] !== 1'b0 && k < 50);
		// a stuck operation is a failure, not something to wait out
		if (rd[0] !== 1'b0) begin
			n_mismatch++;
			$display("unexpected at %0t: operation never went idle", $time);
			test_done();
		end
	endtask : wait_idle

	initial begin
		#(25 * 60000);
		n_mismatch++;
		test_done();
	end

	initial begin
		repeat (12) @(posedge MCLK);
		RESET_N <= 1'b1;
		rd_chk(A_CTRL, 32'h0000_0000);
		rd_chk(A_PRIO, 32'h0000_0000);
		rd_chk(A_GATE, 32'h0000_000E);
		bus(1'b1, 8'h90, 32'h0000_5555);
		rd_chk(8'h90, 32'h0000_0000);
		chk_bit(resp_s, 1'b0);
		bus(1'b1, A_TSB_FIRST, 32'h0000_1000);
		bus(1'b1, 8'h58, 32'h0000_3000);
		$display("reset and map test done");
		for (i = 0; i < 10; i++) begin
			bus(1'b1, A_CTRL, {28'h000_0000, ops[i].ctrl});
			bus(1'b1, A_GATE, {20'h0_0000, ops[i].gate});
			bus(1'b1, A_SP_LO, 32'h0000_5000);
			f0 = n_fault;
			bus(1'b1, A_CMD, {16'h0000, ops[i].cmd});
			wait_idle();
			chk_word(32'(n_fault - f0), 32'(ops[i].fault));
			chk_bit(rd[1], ops[i].fault);
			if (!ops[i].fault) begin
				chk_word({24'h00_0000, rd[11:4]}, {24'h00_0000, ops[i].slot, ops[i].items});
				if (i == 0) chk_word({30'h0000_0000, rd[3:2]}, 32'h0000_0003);
				rd_chk(A_SP_LO, {16'h0000, ops[i].sp});
				if (!ops[i].cmd[8]) rd_chk(A_INDEX, {20'h0_0000, ops[i].idx});
				if (!ops[i].cmd[8] && ops[i].ctrl[0]) chk_bit(h64_s, 1'b1);
			end
			if (i == 0) rd_chk(A_SAVED_LO, 32'h0000_5000);
			if (i == 0) rd_chk(A_SSSEL, 32'h0000_0000);
			bus(1'b1, A_STATUS, 32'h0000_0002);
			$display("operation row %0d done", i);
		end
		bus(1'b1, A_CTRL, 32'h0000_0003);
		bus(1'b1, A_TASKREG, {28'h000_0000, TSB_TYPE64});
		rd_chk(A_TASKREG, 32'h0000_0001);
		bus(1'b1, A_TASKREG, 32'h0000_0003);
		// slot 4 and items 3 still stand from the last return row
		rd_chk(A_STATUS, 32'h0000_0432);
		bus(1'b1, A_STATUS, 32'h0000_0002);
		bus(1'b1, A_TBASE_HI, 32'h0000_1234);
		rd_chk(A_TBASE_HI, 32'h0000_1234);
		bus(1'b1, A_CTRL, 32'h0000_0001);
		bus(1'b1, A_TBASE_HI, 32'h0000_4321);
		rd_chk(A_TBASE_HI, 32'h0000_0000);
		bus(1'b1, A_TBASE_LO, 32'h89AB_CDEF);
		rd_chk(A_TBASE_LO, 32'h89AB_CDEF);
		bus(1'b1, A_TLIMIT, 32'h0001_FFFF);
		rd_chk(A_TLIMIT, 32'h0000_FFFF);
		bus(1'b1, A_IOMAP, 32'h0000_0ABC);
		rd_chk(A_IOMAP, 32'h0000_0ABC);
		bus(1'b1, 8'h8C, 32'h0000_7777);
		rd_chk(8'h8C, 32'h0000_7777);
		$display("task register and table base test done");
		bus(1'b1, A_CTRL, 32'h0000_0003);
		bus(1'b1, A_GATE, 32'h0000_000E);
		bus(1'b1, A_PRIO, 32'h0000_0002);
		rd_chk(A_PRIO, 32'h0000_0002);
		vec <= 8'h31;
		req <= 1'b1;
		repeat (40) @(posedge MCLK);
		chk_bit(taken, 1'b1);
		wait_idle();
		chk_word({28'h000_0000, rd[15:12]}, 32'h0000_0003);
		req <= 1'b0;
		bus(1'b1, A_PRIO, 32'h0000_0003);
		req <= 1'b1;
		repeat (40) @(posedge MCLK);
		chk_bit(taken, 1'b0);
		req <= 1'b0;
		repeat (4) @(posedge MCLK);
		vec <= 8'hF2;
		req <= 1'b1;
		repeat (40) @(posedge MCLK);
		chk_bit(taken, 1'b1);
		req <= 1'b0;
		$display("external priority test done");
		// reset in mid-run: mode, priority and map must fall back
		RESET_N <= 1'b0;
		repeat (2) @(posedge MCLK);
		RESET_N <= 1'b1;
		repeat (2) @(posedge MCLK);
		chk_bit(h64_s, 1'b0);
		chk_bit(rdy_s, 1'b1);
		rd_chk(A_CTRL, 32'h0000_0000);
		rd_chk(A_PRIO, 32'h0000_0000);
		rd_chk(A_IOMAP, 32'h0000_0000);
		$display("mid-run reset test done");
		test_done();
	end
endmodule : lm_intr_unit_tb
